/* common/fsp_pkg.sv */
// constants shared by the suspend / power-down / id command block
// assumes a single 25 MHz system clock; times are converted to cycles here
package fsp_pkg;

   // system clock period
   localparam int CLK_PERIOD_NS = 40;

   // times in ns; every time rounds down to whole cycles, with a minimum of one
   localparam int T_SUSPEND_LATENCY_NS = 20000;
   localparam int T_POWER_DOWN_ENTRY_NS = 3000;
   localparam int T_RELEASE_PLAIN_NS = 3000;
   localparam int T_RELEASE_WITH_ID_NS = 1800;
   localparam int T_RESUME_BUSY_NS = 200;

   localparam int SUS_CYC = (T_SUSPEND_LATENCY_NS / CLK_PERIOD_NS < 1) ? 1 :
                            T_SUSPEND_LATENCY_NS / CLK_PERIOD_NS;
   localparam int PD_CYC = (T_POWER_DOWN_ENTRY_NS / CLK_PERIOD_NS < 1) ? 1 :
                           T_POWER_DOWN_ENTRY_NS / CLK_PERIOD_NS;
   localparam int RES1_CYC = (T_RELEASE_PLAIN_NS / CLK_PERIOD_NS < 1) ? 1 :
                             T_RELEASE_PLAIN_NS / CLK_PERIOD_NS;
   localparam int RES2_CYC = (T_RELEASE_WITH_ID_NS / CLK_PERIOD_NS < 1) ? 1 :
                             T_RELEASE_WITH_ID_NS / CLK_PERIOD_NS;
   localparam int RESUME_CYC = (T_RESUME_BUSY_NS / CLK_PERIOD_NS < 1) ? 1 :
                               T_RESUME_BUSY_NS / CLK_PERIOD_NS;

   // opcodes
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_PP = 8'h02;
   localparam logic [7:0] OP_QPP = 8'h32;
   localparam logic [7:0] OP_SECPP = 8'h42;
   localparam logic [7:0] OP_SE = 8'h20;
   localparam logic [7:0] OP_BE32 = 8'h52;
   localparam logic [7:0] OP_BE64 = 8'hD8;
   localparam logic [7:0] OP_CE_A = 8'hC7;
   localparam logic [7:0] OP_CE_B = 8'h60;
   localparam logic [7:0] OP_SECE = 8'h44;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7A;
   localparam logic [7:0] OP_PDOWN = 8'hB9;
   localparam logic [7:0] OP_RELEASE = 8'hAB;
   localparam logic [7:0] OP_ID = 8'h90;
   localparam logic [7:0] OP_ID_DUAL = 8'h92;

   // frame lengths in serial clock rises
   localparam logic [7:0] LEN_OPC = 8'h08;
   localparam logic [7:0] LEN_WRSR_A = 8'h10;
   localparam logic [7:0] LEN_WRSR_B = 8'h18;
   localparam logic [7:0] LEN_ADDR = 8'h20;
   localparam logic [7:0] LEN_PP_MIN = 8'h28;
   localparam logic [7:0] LEN_QPP_MIN = 8'h22;
   localparam logic [7:0] LEN_DUAL_HDR = 8'h18;
   localparam logic [7:0] DUAL_ADDR_LAST = 8'h13;

   // identity defaults; values are arbitrary
   localparam logic [7:0] MAKER_CODE_DEF = 8'hA5;
   localparam logic [7:0] PART_CODE_DEF = 8'h3C;

   // erase opcodes, including the security-register erase
   function automatic logic is_erase(input logic [7:0] op);
      return op == OP_SE || op == OP_BE32 || op == OP_BE64 ||
             op == OP_CE_A || op == OP_CE_B || op == OP_SECE;
   endfunction

   // program opcodes
   function automatic logic is_prog(input logic [7:0] op);
      return op == OP_PP || op == OP_QPP || op == OP_SECPP;
   endfunction

endpackage

/* common/fsp_pin_if.sv */
// carrier between the pin synchroniser and the command core
// all signals are on clk_in; events are one-cycle pulses
`timescale 1ns/1ps
interface fsp_pin_if;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_act;
   logic cs_fall;
   logic cs_rise;
   logic d0;
   logic d1;
   modport sync (output sclk_rise, sclk_fall, cs_act, cs_fall, cs_rise, d0, d1);
   modport core (input sclk_rise, sclk_fall, cs_act, cs_fall, cs_rise, d0, d1);
endinterface

/* rtl/fsp_pin_sync.sv */
// three-stage synchroniser and edge finder for the serial pins
// assumes the pins are asynchronous to clk_in and slower than clk_in / 6
`timescale 1ns/1ps
module fsp_pin_sync (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic spi_clk_in,
   input wire logic spi_cs_n_in,
   input wire logic io0_in,
   input wire logic io1_in,
   fsp_pin_if.sync pins
);

   // bit 0 serial clock, 1 chip select, 2 io0, 3 io1
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] st;
      logic sclk_rise;
      logic sclk_fall;
      logic cs_fall;
      logic cs_rise;
   } fsp_sync_s;

   fsp_sync_s q_r;
   fsp_sync_s q_nxt;

   // a level counts only once stages two and three agree
   always_comb begin
      q_nxt = q_r;
      q_nxt.s1 = {io1_in, io0_in, spi_cs_n_in, spi_clk_in};
      q_nxt.s2 = q_r.s1;
      q_nxt.s3 = q_r.s2;
      for (int i = 0; i < 4; i++) begin
         if (q_r.s2[i] == q_r.s3[i]) begin
            q_nxt.st[i] = q_r.s3[i];
         end
      end
      q_nxt.sclk_rise = !q_r.st[0] && q_nxt.st[0];
      q_nxt.sclk_fall = q_r.st[0] && !q_nxt.st[0];
      q_nxt.cs_fall = q_r.st[1] && !q_nxt.st[1];
      q_nxt.cs_rise = !q_r.st[1] && q_nxt.st[1];
   end

   // chip select resets high so no frame is seen at start
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         q_r <= '{s1: 4'h2, s2: 4'h2, s3: 4'h2, st: 4'h2, default: '0};
      end else begin
         q_r <= q_nxt;
      end
   end

   assign pins.sclk_rise = q_r.sclk_rise;
   assign pins.sclk_fall = q_r.sclk_fall;
   assign pins.cs_act = !q_r.st[1];
   assign pins.cs_fall = q_r.cs_fall;
   assign pins.cs_rise = q_r.cs_rise;
   assign pins.d0 = q_r.st[2];
   assign pins.d1 = q_r.st[3];

endmodule

/* rtl/fsp_cmd_core.sv */
// suspend / resume, deep power-down and id-read command handling
// Contract
// (RULE1) opcode 75h pauses erase or page program; the code never pauses a security-register erase (44h)
// (RULE2) erase paused: refuse status write and erases
// (RULE3) suspend ignored during whole-chip erase
// (RULE4) program paused: refuse status write and programs
// (RULE5) suspend taken only if not suspended, busy
// (RULE6) suspend sets flag now, busy clears later
// (RULE7) host waits suspend latency after resume
// (RULE8) power-up clears suspend state; resume ignored
// (RULE9) resume taken when suspended, idle; busy soon
// (RULE10) power-down entered within entry time after select
// (RULE11) power-down only if select rises after bit 8
// (RULE12) powered down: only release opcode decoded
// (RULE13) power-up starts in normal operation
// (RULE14) plain release: other opcodes after plain time
// (RULE15) release with dummies streams part code
// (RULE16) release with id: normal after id time
// (RULE17) release opcode ignored while busy
// (RULE18) opcode 90h streams maker then part code
// (RULE19) opcode 92h: dual address, dual alternating codes
// (RULE20) host sends mode bits Fxh for dual id
// (RULE21) ignored opcodes keep outputs off; select ends
// assumes the array engine runs on clk_in and pulses op_done_in when finished
`timescale 1ns/1ps
module fsp_cmd_core
   import fsp_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = MAKER_CODE_DEF, // value is arbitrary
   parameter logic [7:0] PART_CODE = PART_CODE_DEF // value is arbitrary
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic spi_clk_in,
   input wire logic spi_cs_n_in,
   input wire logic io0_in,
   input wire logic io1_in,
   input wire logic op_done_in,
   output logic io0_out,
   output logic io0_oe_out,
   output logic io1_out,
   output logic io1_oe_out,
   output logic cmd_start_out,
   output logic [7:0] cmd_code_out,
   output logic pause_out,
   output logic resume_out,
   output logic busy_out,
   output logic suspend_flag_out,
   output logic power_down_out
);

   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] opc;
      logic [7:0] sh;
      logic [15:0] osr;
      logic [7:0] out_start;
      logic dual;
      logic busy;
      logic suspend_flag;
      logic pd;
      logic [7:0] op_kind;
      logic [7:0] paused_kind;
      logic [9:0] sus_cnt;
      logic [9:0] pd_cnt;
      logic [9:0] rel_cnt;
      logic start;
      logic [7:0] start_code;
      logic pause;
      logic resume;
      logic io0_o;
      logic io0_oe;
      logic io1_o;
      logic io1_oe;
   } fsp_core_s;

   fsp_core_s q_r;
   fsp_core_s q_nxt;
   fsp_pin_if pins ();

   fsp_pin_sync u_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .spi_clk_in(spi_clk_in),
      .spi_cs_n_in(spi_cs_n_in),
      .io0_in(io0_in),
      .io1_in(io1_in),
      .pins(pins.sync)
   );

   // decides whether an opcode may be decoded in the present state
   function automatic logic cmd_ok(input logic [7:0] op, input fsp_core_s s);
      logic r;
      r = 1'b1;
      if (s.rel_cnt != 10'h000) begin
         r = 1'b0; // RULE14 RULE16
      end else if (s.pd) begin
         r = (op == OP_RELEASE) && !s.busy; // RULE12 RULE17
      end else if (op == OP_RELEASE) begin
         r = !s.busy; // RULE17
      end else if (s.busy) begin
         r = (op == OP_SUSPEND) || (op == OP_RESUME);
      end else if (s.suspend_flag && is_erase(s.paused_kind) && (op == OP_WRSR || is_erase(op))) begin
         r = 1'b0; // RULE2
      end else if (s.suspend_flag && is_prog(s.paused_kind) && (op == OP_WRSR || is_prog(op))) begin
         r = 1'b0; // RULE4
      end
      return r;
   endfunction

   // frame length check before a write-type opcode is launched
   function automatic logic len_ok(input logic [7:0] op, input logic [7:0] c);
      logic r;
      r = 1'b0;
      if (op == OP_CE_A || op == OP_CE_B) begin
         r = (c == LEN_OPC);
      end else if (op == OP_SE || op == OP_BE32 || op == OP_BE64 || op == OP_SECE) begin
         r = (c == LEN_ADDR);
      end else if (op == OP_PP || op == OP_SECPP) begin
         r = (c >= LEN_PP_MIN);
      end else if (op == OP_QPP) begin
         r = (c >= LEN_QPP_MIN);
      end else if (op == OP_WRSR) begin
         r = (c == LEN_WRSR_A) || (c == LEN_WRSR_B);
      end
      return r;
   endfunction

   logic [7:0] opc_now;
   logic frame_end_ok;
   logic acc_susp;
   logic acc_res;
   logic acc_pd;
   logic acc_start;
   logic acc_rel;

   // one-byte commands count only when select rises right after bit 8
   always_comb begin
      opc_now = {q_r.sh[6:0], pins.d0};
      frame_end_ok = pins.cs_rise && cmd_ok(q_r.opc, q_r);
      acc_susp = frame_end_ok && q_r.opc == OP_SUSPEND && q_r.cnt == LEN_OPC && // RULE1
                 !q_r.suspend_flag && q_r.busy && // RULE5
                 (q_r.op_kind == OP_SE || q_r.op_kind == OP_BE32 || // RULE3
                  q_r.op_kind == OP_BE64 || is_prog(q_r.op_kind));
      acc_res = frame_end_ok && q_r.opc == OP_RESUME && q_r.cnt == LEN_OPC &&
                q_r.suspend_flag && !q_r.busy; // RULE9
      acc_pd = frame_end_ok && q_r.opc == OP_PDOWN && q_r.cnt == LEN_OPC && // RULE11
               !q_r.busy;
      acc_start = frame_end_ok && !q_r.busy && len_ok(q_r.opc, q_r.cnt);
      acc_rel = frame_end_ok && q_r.opc == OP_RELEASE && q_r.pd &&
                (q_r.cnt == LEN_OPC || q_r.cnt >= LEN_ADDR);
   end

   // next state: frame capture, output shifting, command execution, timers
   always_comb begin
      q_nxt = q_r;
      q_nxt.start = 1'b0;
      q_nxt.resume = 1'b0;
      if (pins.cs_fall) begin
         q_nxt.cnt = 8'h00;
         q_nxt.out_start = 8'h00;
      end
      // input bits taken on serial clock rises
      if (pins.cs_act && pins.sclk_rise) begin
         q_nxt.cnt = (q_r.cnt == 8'hFF) ? q_r.cnt : q_r.cnt + 8'h01;
         q_nxt.sh = (q_r.dual && q_r.cnt >= LEN_OPC) ? {q_r.sh[5:0], pins.d1, pins.d0} : opc_now;
         if (q_r.cnt == 8'h07) begin
            q_nxt.opc = opc_now;
            q_nxt.dual = 1'b0;
            if (cmd_ok(opc_now, q_r)) begin // RULE21
               unique case (opc_now)
                  OP_ID: begin
                     q_nxt.out_start = LEN_ADDR; // RULE18
                     q_nxt.osr = {MAKER_CODE, PART_CODE};
                  end
                  OP_ID_DUAL: begin
                     q_nxt.out_start = LEN_DUAL_HDR; // RULE19 RULE20
                     q_nxt.dual = 1'b1;
                     q_nxt.osr = {MAKER_CODE, PART_CODE};
                  end
                  OP_RELEASE: begin
                     q_nxt.out_start = LEN_ADDR; // RULE15
                     q_nxt.osr = {PART_CODE, PART_CODE};
                  end
                  default: q_nxt.out_start = 8'h00;
               endcase
            end
         end
         // odd address starts with the part code
         if (q_r.opc == OP_ID && q_r.cnt == 8'h1F && pins.d0) begin
            q_nxt.osr = {PART_CODE, MAKER_CODE};
         end
         if (q_r.opc == OP_ID_DUAL && q_r.cnt == DUAL_ADDR_LAST && pins.d0) begin
            q_nxt.osr = {PART_CODE, MAKER_CODE};
         end
      end
      // output on falling edges, msb first; rotation repeats the codes
      if (pins.cs_act && pins.sclk_fall && q_r.out_start != 8'h00 &&
          q_r.cnt >= q_r.out_start) begin
         q_nxt.io1_o = q_r.osr[15];
         q_nxt.io1_oe = 1'b1;
         if (q_r.dual) begin
            q_nxt.io0_o = q_r.osr[14]; // RULE19
            q_nxt.io0_oe = 1'b1;
            q_nxt.osr = {q_r.osr[13:0], q_r.osr[15:14]};
         end else begin
            q_nxt.osr = {q_r.osr[14:0], q_r.osr[15]}; // RULE15 RULE18
         end
      end
      // select high ends every frame and releases the data pins
      if (pins.cs_rise) begin
         q_nxt.out_start = 8'h00; // RULE21
         q_nxt.io0_oe = 1'b0;
         q_nxt.io1_oe = 1'b0;
         q_nxt.dual = 1'b0;
      end
      // array engine finishing clears busy unless a pause is draining
      if (op_done_in && q_r.busy && q_r.sus_cnt == 10'h000) begin
         q_nxt.busy = 1'b0;
      end
      if (q_r.sus_cnt != 10'h000) begin
         q_nxt.sus_cnt = q_r.sus_cnt - 10'h001;
         if (q_r.sus_cnt == 10'h001) begin
            q_nxt.busy = 1'b0; // RULE6
         end
      end
      if (acc_susp) begin
         q_nxt.suspend_flag = 1'b1; // RULE6
         q_nxt.paused_kind = q_r.op_kind;
         q_nxt.pause = 1'b1;
         q_nxt.sus_cnt = 10'(SUS_CYC);
      end
      // busy returns on the next cycle, well inside the resume bound
      if (acc_res) begin
         q_nxt.suspend_flag = 1'b0; // RULE9
         q_nxt.busy = 1'b1;
         q_nxt.op_kind = q_r.paused_kind;
         q_nxt.pause = 1'b0;
         q_nxt.resume = 1'b1;
      end
      if (acc_start) begin
         q_nxt.busy = 1'b1;
         q_nxt.op_kind = q_r.opc;
         q_nxt.start = 1'b1;
         q_nxt.start_code = q_r.opc;
      end
      // power-down entry delayed by the entry time
      if (acc_pd) begin
         q_nxt.pd_cnt = 10'(PD_CYC); // RULE10
      end
      if (q_r.pd_cnt != 10'h000) begin
         q_nxt.pd_cnt = q_r.pd_cnt - 10'h001;
         if (q_r.pd_cnt == 10'h001) begin
            q_nxt.pd = 1'b1; // RULE10
         end
      end
      // release: decoding held off for the matching recovery time
      if (acc_rel) begin
         q_nxt.pd = 1'b0;
         q_nxt.pd_cnt = 10'h000;
         q_nxt.rel_cnt = (q_r.cnt == LEN_OPC) ? 10'(RES1_CYC) : 10'(RES2_CYC); // RULE14 RULE16
      end else if (q_r.rel_cnt != 10'h000) begin
         q_nxt.rel_cnt = q_r.rel_cnt - 10'h001;
      end
   end

   // power-up: not suspended, not powered down, nothing paused
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         q_r <= '0; // RULE8 RULE13
      end else begin
         q_r <= q_nxt;
      end
   end

   assign io0_out = q_r.io0_o;
   assign io0_oe_out = q_r.io0_oe;
   assign io1_out = q_r.io1_o;
   assign io1_oe_out = q_r.io1_oe;
   assign cmd_start_out = q_r.start;
   assign cmd_code_out = q_r.start_code;
   assign pause_out = q_r.pause;
   assign resume_out = q_r.resume;
   assign busy_out = q_r.busy;
   assign suspend_flag_out = q_r.suspend_flag;
   assign power_down_out = q_r.pd;

   // bounds for the timing checks
   localparam int SUS_BOUND = SUS_CYC;
   localparam int PD_BOUND = PD_CYC;
   localparam int RESUME_BOUND = RESUME_CYC;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   susp_gate_a: assert property (acc_susp |-> !q_r.suspend_flag && q_r.busy) // RULE5
      else $error("suspend taken in wrong state");
   susp_chip_a: assert property (acc_susp |-> !(q_r.op_kind == OP_CE_A || // RULE3
                                                q_r.op_kind == OP_CE_B))
      else $error("suspend taken during chip erase");
   susp_timing_a: assert property (acc_susp |=> suspend_flag_out // RULE6
                                   ##[0:SUS_BOUND] !busy_out)
      else $error("suspend did not clear busy in time");
   resume_timing_a: assert property (acc_res |=> !suspend_flag_out // RULE9
                                     ##[0:RESUME_BOUND] busy_out)
      else $error("resume did not restore busy in time");
   erase_refuse_a: assert property (q_r.suspend_flag && is_erase(q_r.paused_kind) && // RULE2
                                    cmd_start_out |-> !is_erase(cmd_code_out) &&
                                    cmd_code_out != OP_WRSR)
      else $error("erase started while erase paused");
   prog_refuse_a: assert property (q_r.suspend_flag && is_prog(q_r.paused_kind) && // RULE4
                                   cmd_start_out |-> !is_prog(cmd_code_out) &&
                                   cmd_code_out != OP_WRSR)
      else $error("program started while program paused");
   pd_entry_a: assert property (acc_pd |=> ##[0:PD_BOUND] power_down_out) // RULE10
      else $error("power-down not entered in time");
   pd_decode_a: assert property (power_down_out && $rose(io1_oe_out) |-> // RULE12
                                 q_r.opc == OP_RELEASE)
      else $error("opcode other than release answered in power-down");
   rel_hold_a: assert property (q_r.rel_cnt != 10'h000 |-> !acc_start && !acc_pd) // RULE14
      else $error("command accepted during release time");
   rel_busy_a: assert property (acc_rel |-> !q_r.busy) // RULE17
      else $error("release acted on while busy");
   cs_idle_a: assert property (pins.cs_rise |=> !io1_oe_out && !io0_oe_out [*2]) // RULE21
      else $error("data pins driven after select rose");

endmodule

/* testbench/fsp_host_model.sv */
// host-side serial controller model that drives the command block's pins
// assumes mode 0 framing with a 320 ns serial clock; block samples pins asynchronously
`timescale 1ns/1ps
module fsp_host_model (
   output logic sclk_out,
   output logic cs_n_out,
   output logic io0_out,
   output logic io1_out,
   input wire logic io0_in,
   input wire logic io1_in
);
   logic drv0 = 1'b0;
   logic drv1 = 1'b0;

   // idle: clock parked low, select high
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      io0_out = 1'b0;
      io1_out = 1'b1;
   end

   // released lines wander so a stale value is never taken for data
   always #80 begin
      if (!drv0) io0_out = ~io0_out;
      if (!drv1) io1_out = ~io1_out;
   end

   // one serial clock period, data already set up
   task automatic pulse();
      #160 sclk_out = 1'b1;
      #160 sclk_out = 1'b0;
   endtask

   // one frame: single-bit phase, dual phase, then read phase
   // reads taken at the pin fall; the answer lags by the synchroniser
   task automatic xfer(input logic [39:0] w, input int ns, input logic [31:0] dw,
                       input int nd, input int nr, input bit dr, output logic [31:0] rd);
      rd = 32'h0000_0000;
      drv0 = 1'b1;
      cs_n_out = 1'b0;
      for (int i = ns - 1; i >= 0; i--) begin
         io0_out = w[i]; // msb first
         pulse();
      end
      drv1 = 1'b1;
      for (int i = nd - 1; i >= 0; i--) begin
         io1_out = dw[2 * i + 1]; // higher bit on io1
         io0_out = dw[2 * i];
         pulse();
      end
      drv0 = 1'b0;
      drv1 = 1'b0;
      for (int i = 0; i < nr; i++) begin
         #160 sclk_out = 1'b1;
         #160 rd = dr ? {rd[29:0], io1_in, io0_in} : {rd[30:0], io1_in};
         sclk_out = 1'b0;
      end
      #160 cs_n_out = 1'b1;
      #200;
   endtask
endmodule

/* testbench/test_fsp_cmd_core.sv */
// self-checking bench for the suspend / power-down / id command block
// assumes fsp_host_model on the pins and the bench acting as array engine
`timescale 1ns/1ps
module test_fsp_cmd_core
   import fsp_pkg::*;
;
   localparam logic [7:0] MAKER = 8'h5A; // value is arbitrary
   localparam logic [7:0] PART = 8'hC3; // value is arbitrary
   localparam logic [39:0] W_SUS = 40'h00_0000_0075;
   localparam logic [39:0] W_RES = 40'h00_0000_007A;
   localparam logic [39:0] W_SE = 40'h00_2000_1000;
   localparam logic [39:0] W_CE = 40'h00_0000_00C7;
   logic clk_in, sys_rst_in, op_done_in;
   logic io0_out, io0_oe_out, io1_out, io1_oe_out, cmd_start_out, pause_out, resume_out;
   logic busy_out, suspend_flag_out, power_down_out;
   logic [7:0] cmd_code_out;
   logic [31:0] rd;
   wire sclk, cs_n, h0, h1, io0_pin, io1_pin;
   int error_cnt = 0;
   int samples_checked = 0;
   int starts = 0;
   int rsm = 0;
   int oe_cyc = 0;
   int n, s0, o0;

   // a pin carries the block's value only while it drives
   assign io0_pin = io0_oe_out ? io0_out : h0;
   assign io1_pin = io1_oe_out ? io1_out : h1;

   fsp_cmd_core #(.MAKER_CODE(MAKER), .PART_CODE(PART)) fsp_cmd_core_inst (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .spi_clk_in(sclk), .spi_cs_n_in(cs_n),
      .io0_in(io0_pin), .io1_in(io1_pin), .op_done_in(op_done_in), .io0_out(io0_out),
      .io0_oe_out(io0_oe_out), .io1_out(io1_out), .io1_oe_out(io1_oe_out),
      .cmd_start_out(cmd_start_out), .cmd_code_out(cmd_code_out), .pause_out(pause_out),
      .resume_out(resume_out), .busy_out(busy_out), .suspend_flag_out(suspend_flag_out),
      .power_down_out(power_down_out));
   fsp_host_model fsp_host_model_inst (.sclk_out(sclk), .cs_n_out(cs_n), .io0_out(h0),
      .io1_out(h1), .io0_in(io0_pin), .io1_in(io1_pin));

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   // cycle counts of pulses and drive, so pulse width errors show too
   always @(posedge clk_in) begin
      if (cmd_start_out === 1'b1) starts++;
      if (resume_out === 1'b1) rsm++;
      if (io0_oe_out === 1'b1 || io1_oe_out === 1'b1) oe_cyc++;
   end

   task automatic chk_bit(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_num(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic endt(input string nm);
      $display("test %s done", nm);
   endtask

   task automatic send(input logic [39:0] w, input int ns, input int nr = 0);
      fsp_host_model_inst.xfer(w, ns, 32'h0000_0000, 0, nr, 1'b0, rd);
   endtask

   // covers the synchroniser delay before a frame takes effect
   task automatic settle();
      repeat (8) @(posedge clk_in);
      #1;
   endtask

   function automatic logic pick(input int w);
      case (w)
         0: return busy_out;
         1: return suspend_flag_out;
         default: return power_down_out;
      endcase
   endfunction

   // bounded wait; n holds the cycles spent
   task automatic wait_val(input int w, input logic v, input int lim);
      n = 0;
      while (pick(w) !== v && n < lim) begin
         @(posedge clk_in);
         #1;
         n++;
      end
   endtask

   task automatic done_pulse();
      @(posedge clk_in);
      #1 op_done_in = 1'b1;
      @(posedge clk_in);
      #1 op_done_in = 1'b0;
      settle();
   endtask

   task automatic suspend();
      send(W_SUS, 8);
      wait_val(1, 1'b1, 12);
      chk_bit("pause", 1'b1, pause_out);
      chk_bit("busy held", 1'b1, busy_out);
      wait_val(0, 1'b0, SUS_CYC + 4);
      chk_bit("busy drop time", 1'b1, n <= SUS_CYC);
   endtask

   task automatic resume();
      int r0;
      r0 = rsm;
      send(W_RES, 8);
      wait_val(1, 1'b0, 12);
      wait_val(0, 1'b1, RESUME_CYC + 2);
      chk_bit("busy back time", 1'b1, n <= RESUME_CYC);
      settle();
      chk_bit("pause", 1'b0, pause_out);
      chk_num("resume pulses", r0 + 1, rsm);
      done_pulse();
      chk_bit("busy", 1'b0, busy_out);
      repeat (SUS_CYC) @(posedge clk_in);
      #1;
   endtask

   task automatic t_reset();
      chk_bit("power down", 1'b0, power_down_out);
      chk_bit("suspend", 1'b0, suspend_flag_out);
      endt("reset");
   endtask

   task automatic t_erase();
      logic [7:0] ops [6] = '{OP_SE, OP_BE32, OP_BE64, OP_SECE, OP_CE_A, OP_CE_B};
      send(W_SE, 32);
      settle();
      chk_num("code", 32'h0000_0020, {24'h00_0000, cmd_code_out});
      suspend();
      s0 = starts;
      o0 = oe_cyc;
      send(40'h00_0000_0100, 16);
      for (int i = 0; i < 6; i++)
         send(i < 4 ? {8'h00, ops[i], 24'h00_0000} : {32'h0000_0000, ops[i]}, i < 4 ? 32 : 8);
      send(W_SUS, 8);
      settle();
      chk_num("starts", s0, starts);
      chk_num("drive cycles", o0, oe_cyc);
      chk_bit("suspend", 1'b1, suspend_flag_out);
      chk_bit("busy", 1'b0, busy_out);
      resume();
      send(W_RES, 8);
      settle();
      chk_bit("busy", 1'b0, busy_out);
      endt("erase suspend");
   endtask

   task automatic t_prog();
      send(40'h02_0000_00A5, 40);
      settle();
      chk_num("code", 32'h0000_0002, {24'h00_0000, cmd_code_out});
      suspend();
      s0 = starts;
      send(40'h02_0000_00A5, 40);
      send(40'h00_C800_0000, 34);
      send(40'h42_0000_0000, 40);
      send(40'h00_0001_0000, 24);
      settle();
      chk_num("starts", s0, starts);
      resume();
      endt("program suspend");
   endtask

   task automatic t_chip();
      send(W_CE, 8);
      settle();
      send(W_SUS, 8);
      settle();
      chk_bit("suspend", 1'b0, suspend_flag_out);
      chk_bit("busy", 1'b1, busy_out);
      done_pulse();
      send(W_SUS, 8);
      settle();
      chk_bit("idle suspend", 1'b0, suspend_flag_out);
      endt("chip erase");
   endtask

   task automatic t_pd();
      send(40'h00_0000_0172, 9);
      wait_val(2, 1'b1, PD_CYC + 8);
      chk_bit("no entry", 1'b0, power_down_out);
      send(40'h00_0000_00B9, 8);
      wait_val(2, 1'b1, PD_CYC + 8);
      chk_bit("entry time", 1'b1, n <= PD_CYC + 5);
      s0 = starts;
      o0 = oe_cyc;
      send(40'h00_9000_0000, 32, 16);
      send(W_CE, 8);
      settle();
      chk_num("drive cycles", o0, oe_cyc);
      chk_bit("power down", 1'b1, power_down_out);
      send(40'h00_0000_00AB, 8);
      send(W_CE, 8);
      settle();
      chk_bit("released", 1'b0, power_down_out);
      chk_num("starts", s0, starts);
      repeat (RES1_CYC) @(posedge clk_in);
      #1;
      send(W_CE, 8);
      settle();
      chk_num("starts", s0 + 1, starts);
      done_pulse();
      endt("power down");
   endtask

   task automatic t_ids();
      send(40'h00_AB00_0000, 32, 16);
      chk_num("part code", {16'h0000, PART, PART}, rd);
      send(40'h00_0000_00B9, 8);
      wait_val(2, 1'b1, PD_CYC + 8);
      send(40'h00_AB00_0000, 32, 8);
      send(40'h00_9000_0000, 32, 32);
      chk_num("codes", {MAKER, PART, MAKER, PART}, rd);
      fsp_host_model_inst.xfer(40'h00_0000_0092, 8, 32'h0000_00F0, 16, 16, 1'b1, rd);
      settle();
      chk_num("dual codes", {MAKER, PART, MAKER, PART}, rd);
      chk_bit("drive off", 1'b0, io1_oe_out);
      endt("ids");
   endtask

   task automatic t_busy_rel();
      send(W_SE, 32);
      settle();
      o0 = oe_cyc;
      send(40'h00_AB00_0000, 32, 16);
      settle();
      chk_num("drive cycles", o0, oe_cyc);
      chk_bit("busy", 1'b1, busy_out);
      done_pulse();
      endt("release while busy");
   endtask

   task automatic t_loss();
      send(W_SE, 32);
      settle();
      suspend();
      @(posedge clk_in);
      #1 sys_rst_in = 1'b1;
      repeat (2) @(posedge clk_in);
      #1 sys_rst_in = 1'b0;
      chk_bit("suspend", 1'b0, suspend_flag_out);
      settle();
      send(W_RES, 8);
      settle();
      chk_bit("busy", 1'b0, busy_out);
      chk_bit("suspend", 1'b0, suspend_flag_out);
      endt("power loss");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      sys_rst_in = 1'b1;
      op_done_in = 1'b0;
      repeat (8) @(posedge clk_in);
      #1 sys_rst_in = 1'b0;
      settle();
      t_reset();
      t_erase();
      t_prog();
      t_chip();
      t_pd();
      t_ids();
      t_busy_rel();
      t_loss();
      results();
   end

   // whole run needs some 10000 cycles
   initial begin
      repeat (75000) @(posedge clk_in);
      error_cnt++;
      $display("[ERR] watchdog expected finish seen timeout");
      results();
   end
endmodule
